// ===== include/ufr_pkg.sv
package ufr_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_CTRL_TWO = 2'h0; // Enables and mode bits
  localparam logic [1:0] OFS_CTRL_THREE = 2'h1; // Ninth bits, DMA, errors
  localparam logic [1:0] OFS_STATUS = 2'h2; // Flag status, read only
  localparam logic [1:0] OFS_DATA = 2'h3; // Data buffer
  // ----------------------------------------------------------------
  // Field positions of control_reg_two
  // ----------------------------------------------------------------
  localparam int C2_TXE_IE = 7; // tx_empty_irq_en
  localparam int C2_TXD_IE = 6; // tx_done_irq_en
  localparam int C2_RXF_IE = 5; // rx_full_irq_en
  localparam int C2_IDL_IE = 4; // idle_irq_en
  localparam int C2_TX_ON = 3; // tx_path_on
  localparam int C2_RX_ON = 2; // Receiver enable
  localparam int C2_NINE = 1; // Nine-bit characters
  // ----------------------------------------------------------------
  // Field positions of control_reg_three
  // ----------------------------------------------------------------
  localparam int C3_RX9 = 7; // rx_ninth_bit, read only
  localparam int C3_TX9 = 6; // tx_ninth_bit
  localparam int C3_RXDMA = 5; // rx_dma_route
  localparam int C3_TXDMA = 4; // tx_dma_route
  localparam int C3_OR_IE = 3; // overrun_irq_en
  localparam int C3_NE_IE = 2; // noise_irq_en
  localparam int C3_FE_IE = 1; // framing_irq_en
  localparam int C3_PE_IE = 0; // parity_irq_en
  // ----------------------------------------------------------------
  // Field positions of status_reg_first
  // ----------------------------------------------------------------
  localparam int ST_TXE = 7; // tx_buffer_empty
  localparam int ST_TXD = 6; // tx_done_flag
  localparam int ST_RXF = 5; // rx_buffer_full
  localparam int ST_IDL = 4; // Idle
  localparam int ST_OVR = 3; // Overrun
  localparam int ST_NF = 2; // noise_flag
  localparam int ST_FE = 1; // framing_error_flag
  localparam int ST_PE = 0; // parity_error_flag
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [5:0] CTRL_THREE_RST = 6'h00; // Writable low bits
  localparam logic [7:0] STATUS_RST = 8'hC0; // Empty and done set
  localparam logic [3:0] IDLE_ONES_8 = 4'hA; // Ones for an idle char
  localparam logic [3:0] IDLE_ONES_9 = 4'hB;
  // ----------------------------------------------------------------
  // Received character with its error marks
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] data; // Nine data bits, bit 8 used in nine-bit mode
    logic noise; // Noise seen while sampling
    logic framing; // Bad stop bit level
    logic parity; // Parity mismatch
  } ufr_rx_char_t;
endpackage

// ===== rtl/ufr_flags.sv
`timescale 1ns/1ps
`default_nettype none
module ufr_flags (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic dma_in,
  output logic [7:0] rdata_out,
  input wire logic rx_input_pin_in,
  input wire logic rx_bit_tick_in,
  input wire logic rx_done_in,
  input wire ufr_pkg::ufr_rx_char_t rx_char_in,
  input wire logic tx_ready_in,
  input wire logic tx_busy_in,
  output logic tx_load_out,
  output logic [8:0] tx_char_out,
  output logic tx_irq_out,
  output logic rx_irq_out,
  output logic err_irq_out,
  output logic dma_tx_req_out,
  output logic dma_rx_req_out
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_two; // control_reg_two
  logic [5:0] ctrl_three; // Writable routing and enable bits
  logic rx_ninth_bit; // Not touched by reset
  logic tx_ninth_bit; // Not touched by reset
  logic [7:0] rx_buf; // Received byte, not touched by reset
  logic [7:0] tx_buf; // Byte waiting for the shifter
  logic tx_pending; // Buffer holds an unsent byte
  logic [7:0] status; // status_reg_first
  logic [7:0] armed; // Flags seen set at the last status read
  logic idle_ok; // Idle may be flagged
  logic [3:0] ones_cnt; // Consecutive ones on the receive input
  logic tx_on_q; // Previous transmitter enable
  logic rx_on_q; // Previous receiver enable
  logic [2:0] pin_sync; // Pin synchroniser chain
  logic rx_level; // Filtered pin level
  // ----------------------------------------------------------------
  // Decoded accesses
  // ----------------------------------------------------------------
  logic st_rd, dat_rd, dat_wr, cpu_dat_rd, cpu_dat_wr;
  logic rx_take, rx_ovr, tx_hand, tx_rise, rx_rise, idle_hit;
  logic [3:0] idle_need;
  logic [7:0] clr_rd; // Status bits cleared by a data read
  logic [7:0] next_rdata;
  // Address match helper, used for every strobe decode below; the read mux uses a case
  function automatic logic hit(input logic [1:0] a, input logic [1:0] o,
                               input logic s);
    hit = s && (a == o);
  endfunction
  assign st_rd = hit(addr_in, ufr_pkg::OFS_STATUS, rd_in);
  assign dat_rd = hit(addr_in, ufr_pkg::OFS_DATA, rd_in);
  assign dat_wr = hit(addr_in, ufr_pkg::OFS_DATA, wr_in);
  assign cpu_dat_rd = dat_rd && !dma_in;
  assign cpu_dat_wr = dat_wr && !dma_in;
  // Any character, marks and all, goes to the buffer only when it is empty
  assign rx_take = rx_done_in && ctrl_two[ufr_pkg::C2_RX_ON] &&
                   !status[ufr_pkg::ST_RXF];
  assign rx_ovr = rx_done_in && ctrl_two[ufr_pkg::C2_RX_ON] &&
                  status[ufr_pkg::ST_RXF];
  assign tx_hand = tx_pending && tx_ready_in &&
                   ctrl_two[ufr_pkg::C2_TX_ON];
  assign tx_rise = ctrl_two[ufr_pkg::C2_TX_ON] && !tx_on_q;
  assign rx_rise = ctrl_two[ufr_pkg::C2_RX_ON] && !rx_on_q;
  assign idle_need = ctrl_two[ufr_pkg::C2_NINE] ? ufr_pkg::IDLE_ONES_9 :
                     ufr_pkg::IDLE_ONES_8;
  assign idle_hit = rx_bit_tick_in && rx_level &&
                    (ones_cnt == idle_need - 4'h1);
  // ----------------------------------------------------------------
  // Data-read clears: a DMA read clears full outright, a CPU read only
  // clears what the preceding status read saw set
  // ----------------------------------------------------------------
  always_comb begin
    clr_rd = 8'h00;
    if (cpu_dat_rd) begin
      // overrun needs the earlier status sighting
      clr_rd = armed & 8'h3F;
    end
    if (dat_rd && dma_in) begin
      clr_rd[ufr_pkg::ST_RXF] = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Receive input pin: three flops, change taken when last two agree
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pin_sync <= 3'h7;
      rx_level <= 1'b1;
    end else begin
      pin_sync <= {pin_sync[1:0], rx_input_pin_in};
      if (pin_sync[1] == pin_sync[2]) begin
        rx_level <= pin_sync[2];
      end
    end
  end
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl_two <= ufr_pkg::CTRL_TWO_RST;
      // reset clears the error enables and routes
      ctrl_three <= ufr_pkg::CTRL_THREE_RST;
      tx_on_q <= 1'b0;
      rx_on_q <= 1'b0;
    end else begin
      tx_on_q <= ctrl_two[ufr_pkg::C2_TX_ON];
      rx_on_q <= ctrl_two[ufr_pkg::C2_RX_ON];
      if (hit(addr_in, ufr_pkg::OFS_CTRL_TWO, wr_in)) begin
        ctrl_two <= {wdata_in[7:1], 1'b0};
      end
      if (hit(addr_in, ufr_pkg::OFS_CTRL_THREE, wr_in)) begin
        ctrl_three <= wdata_in[5:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Ninth bits and data buffers: reset leaves them alone
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (hit(addr_in, ufr_pkg::OFS_CTRL_THREE, wr_in)) begin
      tx_ninth_bit <= wdata_in[ufr_pkg::C3_TX9];
    end
    if (rx_take) begin
      // only a taken character lands; overrun drops it
      rx_buf <= rx_char_in.data[7:0];
      // ninth bit latched with the byte
      rx_ninth_bit <= ctrl_two[ufr_pkg::C2_NINE] ? rx_char_in.data[8] :
                      rx_char_in.data[7];
    end
    if (dat_wr) begin
      tx_buf <= wdata_in;
    end
  end
  // ----------------------------------------------------------------
  // Transmit handover to the shift register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      tx_pending <= 1'b0;
      tx_load_out <= 1'b0;
      tx_char_out <= 9'h000;
    end else begin
      tx_load_out <= tx_hand;
      if (tx_hand) begin
        // ninth bit moves with the byte
        tx_char_out <= {tx_ninth_bit, tx_buf};
      end
      // A write in the handover cycle queues the new byte
      if (dat_wr) begin
        tx_pending <= 1'b1;
      end else if (tx_hand) begin
        tx_pending <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Status read snapshot, used by the two-step clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      armed <= 8'h00;
    end else if (st_rd) begin
      armed <= status;
    end else begin
      // Used bits drop so a later read needs a fresh status read
      if (cpu_dat_rd) begin
        armed[5:0] <= 6'h00;
      end
      if (cpu_dat_wr) begin
        armed[ufr_pkg::ST_TXE] <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Idle detection on the receive input
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ones_cnt <= 4'h0;
      idle_ok <= 1'b0;
    end else begin
      if (!rx_level) begin
        ones_cnt <= 4'h0;
      end else if (rx_bit_tick_in && ones_cnt < idle_need) begin
        ones_cnt <= ones_cnt + 4'h1;
      end
      // blocked after enable and after each clear
      if (rx_take) begin
        idle_ok <= 1'b1;
      end else if (rx_rise || clr_rd[ufr_pkg::ST_IDL] || idle_hit) begin
        idle_ok <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Status flags: in every flag but done a hardware set beats the clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      // empty and done come out of reset set
      status <= ufr_pkg::STATUS_RST;
    end else begin
      // CPU write after status read, or any DMA write
      // set on handover; set on each enable
      if (tx_hand || tx_rise) begin
        status[ufr_pkg::ST_TXE] <= 1'b1;
      end else if ((cpu_dat_wr && armed[ufr_pkg::ST_TXE]) ||
                   (dat_wr && dma_in)) begin
        status[ufr_pkg::ST_TXE] <= 1'b0;
      end
      // queued data or a busy line clears done
      // set when empty and nothing is sent
      if (dat_wr || tx_pending || tx_busy_in) begin
        status[ufr_pkg::ST_TXD] <= 1'b0;
      end else if (status[ufr_pkg::ST_TXE]) begin
        status[ufr_pkg::ST_TXD] <= 1'b1;
      end
      if (rx_take) begin
        status[ufr_pkg::ST_RXF] <= 1'b1;
      end else if (clr_rd[ufr_pkg::ST_RXF]) begin
        status[ufr_pkg::ST_RXF] <= 1'b0;
      end
      // idle after the full run of ones
      if (idle_hit && idle_ok) begin
        status[ufr_pkg::ST_IDL] <= 1'b1;
      end else if (clr_rd[ufr_pkg::ST_IDL]) begin
        status[ufr_pkg::ST_IDL] <= 1'b0;
      end
      // overrun on a character while full
      if (rx_ovr) begin
        status[ufr_pkg::ST_OVR] <= 1'b1;
      end else if (clr_rd[ufr_pkg::ST_OVR]) begin
        status[ufr_pkg::ST_OVR] <= 1'b0;
      end
      // error marks of a taken char
      for (int i = ufr_pkg::ST_PE; i <= ufr_pkg::ST_NF; i++) begin
        if (rx_take && (i == ufr_pkg::ST_NF ? rx_char_in.noise :
                        i == ufr_pkg::ST_FE ? rx_char_in.framing :
                        rx_char_in.parity)) begin
          status[i] <= 1'b1;
        end else if (clr_rd[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Requests: registered so the outputs come straight from flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
      err_irq_out <= 1'b0;
      dma_tx_req_out <= 1'b0;
      dma_rx_req_out <= 1'b0;
    end else begin
      // empty routed to CPU or DMA; done to CPU
      tx_irq_out <= (status[ufr_pkg::ST_TXE] &&
                     ctrl_two[ufr_pkg::C2_TXE_IE] &&
                     !ctrl_three[ufr_pkg::C3_TXDMA]) ||
                    (status[ufr_pkg::ST_TXD] &&
                     ctrl_two[ufr_pkg::C2_TXD_IE]);
      dma_tx_req_out <= status[ufr_pkg::ST_TXE] &&
                        ctrl_two[ufr_pkg::C2_TXE_IE] &&
                        ctrl_three[ufr_pkg::C3_TXDMA];
      // rx DMA route silences the full and idle interrupts
      rx_irq_out <= !ctrl_three[ufr_pkg::C3_RXDMA] &&
                    ((status[ufr_pkg::ST_RXF] &&
                      ctrl_two[ufr_pkg::C2_RXF_IE]) ||
                     (status[ufr_pkg::ST_IDL] &&
                      ctrl_two[ufr_pkg::C2_IDL_IE]));
      dma_rx_req_out <= status[ufr_pkg::ST_RXF] &&
                        ctrl_two[ufr_pkg::C2_RXF_IE] &&
                        ctrl_three[ufr_pkg::C3_RXDMA];
      err_irq_out <= |(status[3:0] & ctrl_three[3:0]);
    end
  end
  // ----------------------------------------------------------------
  // Read data, valid in the cycle after the strobe only
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        ufr_pkg::OFS_CTRL_TWO: next_rdata = ctrl_two;
        ufr_pkg::OFS_CTRL_THREE: begin
          next_rdata = {rx_ninth_bit, tx_ninth_bit, ctrl_three};
        end
        ufr_pkg::OFS_STATUS: next_rdata = status;
        ufr_pkg::OFS_DATA: next_rdata = rx_buf;
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  a_ninth_capture:
    assert property (rx_take && ctrl_two[ufr_pkg::C2_NINE] |=>
                     rx_ninth_bit == $past(rx_char_in.data[8]))
    else $error("ninth bit not captured");
  a_ninth_copy:
    assert property (rx_take && !ctrl_two[ufr_pkg::C2_NINE] |=>
                     rx_ninth_bit == rx_buf[7])
    else $error("ninth bit not a copy of bit 7");
  a_tx_ninth:
    assert property (tx_hand |=> tx_load_out &&
                     tx_char_out[8] == $past(tx_ninth_bit))
    else $error("tx ninth bit not loaded");
  a_rx_dma_quiet:
    assert property (ctrl_three[ufr_pkg::C3_RXDMA] |=> !rx_irq_out)
    else $error("rx irq while DMA routed");
  a_tx_route:
    assert property (!(tx_irq_out && dma_tx_req_out &&
                       !status[ufr_pkg::ST_TXD]))
    else $error("tx empty routed both ways");
  a_empty_set:
    assert property (tx_hand |=> status[ufr_pkg::ST_TXE])
    else $error("empty not set on handover");
  a_empty_clear:
    assert property (!tx_hand && !tx_rise && dat_wr && dma_in |=>
                     !status[ufr_pkg::ST_TXE])
    else $error("DMA write did not clear empty");
  a_done_clear:
    assert property (dat_wr |=> !status[ufr_pkg::ST_TXD])
    else $error("done not cleared by write");
  a_full_keep:
    assert property (rx_ovr |=> status[ufr_pkg::ST_OVR] &&
                     rx_buf == $past(rx_buf))
    else $error("overrun lost buffer");
  a_ovr_seq:
    assert property (status[ufr_pkg::ST_OVR] &&
                     !armed[ufr_pkg::ST_OVR] && cpu_dat_rd |=>
                     status[ufr_pkg::ST_OVR])
    else $error("overrun cleared without status read");
  a_err_irq:
    assert property (##1 err_irq_out ==
                     $past(|(status[3:0] & ctrl_three[3:0])))
    else $error("error irq mismatch");
endmodule
`default_nettype wire

// ===== verification/ufr_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufr_far_model (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic send_in,
  input wire ufr_pkg::ufr_rx_char_t char_in,
  input wire logic tx_load_in,
  output logic rx_pin_out,
  output logic rx_tick_out,
  output logic rx_done_out,
  output ufr_pkg::ufr_rx_char_t rx_char_out,
  output logic tx_ready_out,
  output logic tx_busy_out
);
  // ----------------
  // Line side state
  // ----------------
  logic [2:0] tick_cnt; // Bit time divider, free running
  logic [3:0] busy_cnt; // Cycles left on the byte being shifted
  logic [3:0] low_cnt; // Cycles of frame still shown low on the pin
  // Bit tick every eight cycles, so an idle char takes 80 cycles, 88 with nine bits
  always_ff @(posedge clock_in) begin
    tick_cnt <= srst_in ? 3'h0 : tick_cnt + 3'h1;
    rx_tick_out <= (tick_cnt == 3'h7);
  end
  // character handed in with marks
  // Between frames the char bus toggles each cycle, a stale copy every other cycle
  // Pin stays low for several cycles so the three-flop filter sees it
  always_ff @(posedge clock_in) begin
    rx_done_out <= send_in;
    rx_pin_out <= !send_in && (low_cnt == 4'h0);
    if (srst_in) begin
      rx_char_out <= '1;
      low_cnt <= 4'h0;
    end else begin
      rx_char_out <= send_in ? char_in : ~rx_char_out;
      if (send_in) begin
        low_cnt <= 4'h8;
      end else if (low_cnt != 4'h0) begin
        low_cnt <= low_cnt - 4'h1;
      end
    end
  end
  // shifter busy for eight cycles after each load
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      busy_cnt <= 4'h0;
    end else if (tx_load_in) begin
      busy_cnt <= 4'h8;
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
    end
  end
  // Ready only while nothing is on the line
  assign tx_busy_out = (busy_cnt != 4'h0);
  assign tx_ready_out = ~tx_busy_out;
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic dma_in = 1'b0, send = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00, d, rdata_out;
  logic [8:0] v, tx_char_out;
  logic [2:0] m;
  logic [3:0] en;
  ufr_pkg::ufr_rx_char_t ch = '0, rx_char_in;
  logic rx_input_pin_in, rx_bit_tick_in, rx_done_in, tx_ready_in;
  logic tx_busy_in, tx_load_out, tx_irq_out, rx_irq_out, err_irq_out;
  logic dma_tx_req_out, dma_rx_req_out;
  int mismatches = 0, num_checks = 0;
  ufr_flags u_ufr_flags (.clock_in, .srst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .dma_in, .rdata_out, .rx_input_pin_in, .rx_bit_tick_in,
    .rx_done_in, .rx_char_in, .tx_ready_in, .tx_busy_in, .tx_load_out,
    .tx_char_out, .tx_irq_out, .rx_irq_out, .err_irq_out, .dma_tx_req_out,
    .dma_rx_req_out);
  ufr_far_model u_ufr_far_model (.clock_in, .srst_in, .send_in(send),
    .char_in(ch), .tx_load_in(tx_load_out), .rx_pin_out(rx_input_pin_in),
    .rx_tick_out(rx_bit_tick_in), .rx_done_out(rx_done_in),
    .rx_char_out(rx_char_in), .tx_ready_out(tx_ready_in),
    .tx_busy_out(tx_busy_in));
  // 20 MHz clock
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  // ----------------
  // Bus and checks
  // ----------------
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] x,
                        input logic dm);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= x;
    wr_in <= 1'b1;
    dma_in <= dm;
    @(posedge clock_in);
    wr_in <= 1'b0;
    dma_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, input logic dm);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    dma_in <= dm;
    @(posedge clock_in);
    rd_in <= 1'b0;
    dma_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // One character from the far side, then flags and requests settle
  task automatic rx_send(input logic [8:0] x, input logic [2:0] mk);
    @(posedge clock_in);
    send <= 1'b1;
    ch <= {x, mk};
    @(posedge clock_in);
    send <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic check(input string n, input logic [8:0] s,
                       input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bounded wait for a byte handed to the shifter
  task automatic wait_load();
    int n;
    n = 0;
    while (tx_load_out !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n == 40) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Error request is any flagged error whose enable is set
  function automatic logic exp_err(input logic [3:0] f, input logic [3:0] e);
    return |(f & e);
  endfunction
  initial begin
    void'($urandom(57));
    repeat (6) @(posedge clock_in);
    srst_in <= 1'b0;
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    check("status", d, ufr_pkg::STATUS_RST);
    rd_reg(ufr_pkg::OFS_CTRL_THREE, 1'b0);
    check("ctrl3", d[5:0], ufr_pkg::CTRL_THREE_RST);
    // Receiver on with no char yet: idle must stay blocked
    wr_reg(ufr_pkg::OFS_CTRL_TWO, 8'h24, 1'b0);
    wait_cyc(120);
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    check("idle_blk", d[ufr_pkg::ST_IDL], 1'b0);
    // Random chars, marks and enables; odd passes overrun mid-clear
    for (int i = 0; i < 6; i++) begin
      v = 9'($urandom);
      m = 3'($urandom);
      en = 4'($urandom);
      wr_reg(ufr_pkg::OFS_CTRL_TWO, {6'h09, i < 3, 1'b0}, 1'b0);
      wr_reg(ufr_pkg::OFS_CTRL_THREE, {4'h0, en}, 1'b0);
      rx_send(v, m);
      check("rx_irq", rx_irq_out, 1'b1);
      rd_reg(ufr_pkg::OFS_CTRL_THREE, 1'b0);
      check("rx9", d[7], (i < 3) ? v[8] : v[7]);
      rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
      check("flags", {d[5], d[3:0]}, {2'b10, m});
      if (i[0]) rx_send(~v, 3'h0);
      check("err_irq", err_irq_out, exp_err({i[0], m}, en));
      rd_reg(ufr_pkg::OFS_DATA, 1'b0);
      check("rx_data", d, v[7:0]);
      rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
      check("clr", {d[5], d[3:0]}, {1'b0, i[0], 3'h0});
      rd_reg(ufr_pkg::OFS_DATA, 1'b0);
      rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
      check("ovr_clr", d[ufr_pkg::ST_OVR], 1'b0);
    end
    // Receiver DMA route: request only, DMA read clears full
    wr_reg(ufr_pkg::OFS_CTRL_THREE, 8'h20, 1'b0);
    wr_reg(ufr_pkg::OFS_CTRL_TWO, 8'h24, 1'b0);
    rx_send(9'h05A, 3'h0);
    check("rx_dma", {dma_rx_req_out, rx_irq_out}, 2'b10);
    rd_reg(ufr_pkg::OFS_DATA, 1'b1);
    check("dma_rd", d, 8'h5A);
    // Idle after enough ones, raised on the CPU route only
    wr_reg(ufr_pkg::OFS_CTRL_THREE, 8'h00, 1'b0);
    wr_reg(ufr_pkg::OFS_CTRL_TWO, 8'h14, 1'b0);
    wait_cyc(120);
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    check("idle", {d[ufr_pkg::ST_IDL], d[ufr_pkg::ST_RXF]}, 2'b10);
    check("idle_irq", rx_irq_out, 1'b1);
    wr_reg(ufr_pkg::OFS_CTRL_THREE, 8'h20, 1'b0);
    wait_cyc(2);
    check("idle_dma", rx_irq_out, 1'b0);
    rd_reg(ufr_pkg::OFS_DATA, 1'b0);
    wait_cyc(120);
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    check("idle_reblk", d[ufr_pkg::ST_IDL], 1'b0);
    // Transmit: DMA route set before the transmitter is enabled
    wr_reg(ufr_pkg::OFS_CTRL_THREE, 8'h50, 1'b0);
    wr_reg(ufr_pkg::OFS_CTRL_TWO, 8'h88, 1'b0);
    wait_cyc(2);
    check("tx_req", {dma_tx_req_out, tx_irq_out}, 2'b10);
    v = 9'($urandom);
    wr_reg(ufr_pkg::OFS_DATA, v[7:0], 1'b1);
    wait_load();
    check("tx_char", tx_char_out, {1'b1, v[7:0]});
    wr_reg(ufr_pkg::OFS_DATA, ~v[7:0], 1'b1);
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    check("tx_busy", d[7:6], 2'b00);
    check("tx_req0", dma_tx_req_out, 1'b0);
    wait_load();
    check("tx_char2", tx_char_out, {1'b1, ~v[7:0]});
    wait_cyc(14);
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    check("tx_idle", d[7:6], 2'b11);
    // CPU route: empty and done raise the transmitter interrupt
    wr_reg(ufr_pkg::OFS_CTRL_THREE, 8'h00, 1'b0);
    wr_reg(ufr_pkg::OFS_CTRL_TWO, 8'hC8, 1'b0);
    wait_cyc(2);
    check("tx_cpu", {dma_tx_req_out, tx_irq_out}, 2'b01);
    wr_reg(ufr_pkg::OFS_DATA, v[7:0], 1'b0);
    wait_load();
    check("tx_char3", tx_char_out, {1'b0, v[7:0]});
    rd_reg(ufr_pkg::OFS_STATUS, 1'b0);
    wr_reg(ufr_pkg::OFS_DATA, 8'hA5, 1'b0);
    wait_cyc(1);
    check("tx_cpu0", tx_irq_out, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
